// File: rtl/rsc_pkg.sv
// Constants for the resolver offset and phase calibration block
package rsc_pkg;
    // ==========================================
    // Clock and time figures
    localparam int RSC_CLK_MHZ = 50;
    localparam int RSC_INIT_MIN_NS = 200000;
    localparam int RSC_INIT_MAX_NS = 400000;
    localparam int RSC_INIT_STEP_NS = 1000;
    localparam int RSC_RT_GAP_NS = 400000;
    localparam int RSC_HOLD_NS = 10000;
    localparam int RSC_PERIOD_MS = 100;
    localparam int RSC_RT_LIMIT_MS = 5;
    localparam int RSC_EXC_MASK_MS = 10;
    localparam int RSC_MAN_STEP_NS = 400;
    localparam int RSC_AUTO_STEP_NS = 100;
    localparam int RSC_EXC_MIN_KHZ = 10;
    localparam int RSC_EXC_MAX_KHZ = 20;
    // Least times round up, longest round down
    localparam int RSC_INIT_MIN_CYC = (RSC_INIT_MIN_NS * RSC_CLK_MHZ + 999) / 1000;
    localparam int RSC_INIT_MAX_CYC = RSC_INIT_MAX_NS * RSC_CLK_MHZ / 1000;
    localparam int RSC_INIT_STEP_CYC = RSC_INIT_STEP_NS * RSC_CLK_MHZ / 1000;
    localparam int RSC_RT_GAP_CYC = (RSC_RT_GAP_NS * RSC_CLK_MHZ + 999) / 1000;
    localparam int RSC_HOLD_CYC = RSC_HOLD_NS * RSC_CLK_MHZ / 1000;
    localparam int RSC_PERIOD_CYC = RSC_PERIOD_MS * RSC_CLK_MHZ * 1000;
    localparam int RSC_RT_LIMIT_CYC = RSC_RT_LIMIT_MS * RSC_CLK_MHZ * 1000;
    localparam int RSC_EXC_MASK_CYC = RSC_EXC_MASK_MS * RSC_CLK_MHZ * 1000;
    localparam int RSC_TICK_CYC = RSC_AUTO_STEP_NS * RSC_CLK_MHZ / 1000;
    localparam int RSC_MAN_SCALE = RSC_MAN_STEP_NS / RSC_AUTO_STEP_NS;
    localparam int RSC_PER_MIN_TICK = 1000000 / (RSC_EXC_MAX_KHZ * RSC_AUTO_STEP_NS);
    localparam int RSC_PER_MAX_TICK = 1000000 / (RSC_EXC_MIN_KHZ * RSC_AUTO_STEP_NS);
    // ==========================================
    // Calibration
    localparam int RSC_TRIM_W = 6;
    localparam int RSC_TOGGLES = 4;
    localparam logic [1:0] RSC_LAST_BLK = 2'h3;
    // ==========================================
    // Register map
    localparam logic [7:0] RSC_CTRL_OFF = 8'h00;
    localparam logic [7:0] RSC_STAT_OFF = 8'h04;
    localparam logic [7:0] RSC_TRIM_OFF = 8'h08;
    localparam logic [7:0] RSC_PHASE_OFF = 8'h0c;
    localparam int RSC_CTRL_EXC = 0;
    localparam int RSC_CTRL_AUTO = 1;
    localparam int RSC_CTRL_MAN = 2;
    localparam int RSC_CTRL_VAL = 8;
    localparam int RSC_STAT_CAL = 0;
    localparam int RSC_STAT_LOOP = 1;
    localparam int RSC_STAT_DIAG = 2;
    localparam int RSC_STAT_BUSY = 16;
    localparam int RSC_STAT_INIT = 17;
    // Quarter-wave sine, 16 points, 9-bit magnitude
    localparam logic [9:0] RSC_SIN_TBL [16] = '{10'h000, 10'h032, 10'h064, 10'h094,
        10'h0c4, 10'h0f1, 10'h11c, 10'h144, 10'h169, 10'h18b, 10'h1a9, 10'h1c3,
        10'h1d8, 10'h1e9, 10'h1f5, 10'h1fc};
    typedef enum logic [2:0] {C_IDLE, C_INIT, C_INIT_END, C_RT_WAIT, C_RT_STEP} rsc_cal_e;
endpackage

// File: rtl/rsc_cal.sv
// Offset calibration, phase delay and fault collection with APB registers
// How it works
// R1: Initial correction on diagnostics entry, 200-400us
// R2: Initial pass trims all four blocks
// R3: Periodic pass trims front-end only
// R4: Short inputs, compare, drive trim DAC
// R5: Step by comparator; toggling means done
// R6: Periodic routine every 100 ms
// R7: Trim changes at most every 400us
// R8: Loop blinded at most 10us per step
// R9: Angle stays valid during periodic routine
// R10: Trim change at exciter zero crossing
// R11: Failure sets fault flag, retry 100ms
// R12: Successful pass clears fault flag
// R13: Two bits pick none, auto, manual
// R14: Manual delay +-12.4us in 0.4us steps
// R15: Auto uses larger sine/cosine mismatch
// R16: Auto steps 100ns, 10-20 kHz only
// R17: Feedback sine/cosine from table to DACs
// R18: Tracking error watched for lost tracking
// R19: Out-of-threshold signals set fault flags
// R20: Faults drive pin, disable exciter; exciter_off is set only by the EXC_N exciter flags while exc_en is set
// R21: Exciter faults masked 10ms after enable
// R22: Fail on trim exhausted or timeout
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/1ns
module rsc_cal
    import rsc_pkg::*;
#(
    parameter int DIAG_N = 8,
    parameter int EXC_N = 4,
    parameter int PERIOD_CYC = RSC_PERIOD_CYC,
    parameter int RT_GAP_CYC = RSC_RT_GAP_CYC,
    parameter int INIT_MIN_CYC = RSC_INIT_MIN_CYC,
    parameter int INIT_MAX_CYC = RSC_INIT_MAX_CYC,
    parameter int RT_LIMIT_CYC = RSC_RT_LIMIT_CYC,
    parameter int EXC_MASK_CYC = RSC_EXC_MASK_CYC
)(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic dev_diag,
    input wire logic dev_normal,
    input wire logic [9:0] angle,
    input wire logic cal_cmp,
    input wire logic exciter_ref,
    input wire logic sin_zc,
    input wire logic cos_zc,
    input wire logic err_high,
    input wire logic [DIAG_N-1:0] diag_in,
    output logic [RSC_TRIM_W-1:0] trim_code,
    output logic [1:0] trim_sel,
    output logic cal_short,
    output logic loop_hold,
    output logic angle_valid,
    output logic [9:0] sin_dac,
    output logic [9:0] cos_dac,
    output logic [8:0] ref_delay,
    output logic exciter_off,
    output logic fault
);
    localparam int SW = 5 + DIAG_N;
    localparam int I_CMP = 0;
    localparam int I_REF = 1;
    localparam int I_SIN = 2;
    localparam int I_COS = 3;
    localparam int I_ERR = 4;
    localparam logic [RSC_TRIM_W-1:0] TRIM_MAX = '1;

    typedef struct packed {
        rsc_cal_e cs;
        logic [1:0] blk;
        logic [3:0][RSC_TRIM_W-1:0] trim;
        logic last_cmp;
        logic [2:0] rev;
        logic [22:0] tmr;
        logic [22:0] gap;
        logic [22:0] per;
        logic [9:0] hold;
        logic init_done;
        logic cal_fault;
        logic [SW-1:0] s1;
        logic [SW-1:0] s2;
        logic [SW-1:0] s3;
        logic [2:0] tick;
        logic [7:0] mt;
        logic [7:0] ms;
        logic [7:0] mc;
        logic [10:0] rper;
        logic [7:0] auto_val;
        logic exc_en;
        logic ph_auto;
        logic ph_man;
        logic [5:0] ph_val;
        logic [DIAG_N-1:0] flags;
        logic loop_flt;
        logic [22:0] exm;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [RSC_TRIM_W-1:0] trim_code;
        logic short_in;
        logic hold_loop;
        logic angle_valid;
        logic [9:0] sin_dac;
        logic [9:0] cos_dac;
        logic [8:0] ref_delay;
        logic exc_off;
        logic fault;
    } rsc_state_s;

    rsc_state_s st_r;
    rsc_state_s st_nxt;

    // ==========================================
    // Helpers
    function automatic logic [9:0] sin10(input logic [9:0] a);
        logic [9:0] mag;
        mag = a[8] ? RSC_SIN_TBL[4'hf - a[7:4]] : RSC_SIN_TBL[a[7:4]];
        return a[9] ? 10'h200 - mag : 10'h200 + mag;
    endfunction

    function automatic logic [22:0] sat23(input logic [22:0] v);
        return (v == '1) ? v : v + 23'h1;
    endfunction

    logic [SW-1:0] rise;
    logic cmpv;
    logic [RSC_TRIM_W-1:0] step_trim;
    logic step_exh;
    logic [2:0] step_rev;
    logic step_ok;
    logic setup;
    logic wr;
    logic [DIAG_N-1:0] diag_set;
    logic [DIAG_N-1:0] w1c;

    assign rise = st_r.s2 & ~st_r.s3;
    assign cmpv = st_r.s2[I_CMP];
    assign setup = psel & ~penable;
    assign wr = psel & penable & pwrite & st_r.pready;

    always_comb
    begin
        step_trim = cmpv ? st_r.trim[st_r.blk] - 1'b1 : st_r.trim[st_r.blk] + 1'b1; // R5
        step_exh = cmpv ? (st_r.trim[st_r.blk] == '0) : (st_r.trim[st_r.blk] == TRIM_MAX);
        step_rev = (cmpv != st_r.last_cmp) ? st_r.rev + 3'h1 : st_r.rev;
        step_ok = (step_rev >= 3'(RSC_TOGGLES)); // R5
        diag_set = st_r.s2[SW-1:5];
        if (st_r.exm != '0)
        begin
            diag_set[EXC_N-1:0] = '0; // R21
        end
        w1c = (wr && paddr == RSC_STAT_OFF) ? pwdata[RSC_STAT_DIAG +: DIAG_N] : '0;
    end

    // ==========================================
    // Next state
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.s1 = {diag_in, err_high, cos_zc, sin_zc, exciter_ref, cal_cmp};
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;

        // Calibration sequencer
        unique case (st_r.cs)
            C_IDLE:
            begin
                if (dev_diag && !st_r.init_done)
                begin
                    st_nxt.cs = C_INIT; // R1
                    st_nxt.blk = 2'h0;
                    st_nxt.tmr = '0;
                    st_nxt.gap = '0;
                    st_nxt.rev = '0;
                    st_nxt.last_cmp = cmpv;
                end
                else if (st_r.init_done && dev_normal)
                begin
                    st_nxt.per = st_r.per + 23'h1;
                    if (st_r.per >= 23'(PERIOD_CYC - 1))
                    begin
                        st_nxt.per = '0; // R6 R11
                        st_nxt.cs = C_RT_WAIT;
                        st_nxt.blk = 2'h0; // R3
                        st_nxt.tmr = '0;
                        st_nxt.gap = '0;
                        st_nxt.rev = '0;
                        st_nxt.last_cmp = cmpv;
                    end
                end
            end
            C_INIT:
            begin
                st_nxt.tmr = sat23(st_r.tmr);
                st_nxt.gap = st_r.gap + 23'h1;
                if (st_r.tmr >= 23'(INIT_MAX_CYC - 1))
                begin
                    st_nxt.cs = C_IDLE; // R22
                    st_nxt.cal_fault = 1'b1;
                    st_nxt.init_done = 1'b1;
                    st_nxt.per = '0;
                end
                else if (st_r.gap >= 23'(RSC_INIT_STEP_CYC - 1))
                begin
                    st_nxt.gap = '0;
                    if (step_ok)
                    begin
                        st_nxt.rev = '0; // R2
                        st_nxt.blk = st_r.blk + 2'h1;
                        if (st_r.blk == RSC_LAST_BLK)
                        begin
                            st_nxt.cs = C_INIT_END;
                            st_nxt.blk = st_r.blk;
                        end
                    end
                    else if (step_exh)
                    begin
                        st_nxt.cs = C_IDLE; // R22
                        st_nxt.cal_fault = 1'b1;
                        st_nxt.init_done = 1'b1;
                        st_nxt.per = '0;
                    end
                    else
                    begin
                        st_nxt.trim[st_r.blk] = step_trim; // R4
                        st_nxt.rev = step_rev;
                        st_nxt.last_cmp = cmpv;
                    end
                end
            end
            C_INIT_END:
            begin
                st_nxt.tmr = sat23(st_r.tmr);
                if (st_r.tmr >= 23'(INIT_MIN_CYC - 1))
                begin
                    st_nxt.cs = C_IDLE; // R1 R12
                    st_nxt.init_done = 1'b1;
                    st_nxt.cal_fault = 1'b0;
                    st_nxt.per = '0;
                end
            end
            C_RT_WAIT:
            begin
                st_nxt.tmr = sat23(st_r.tmr);
                st_nxt.gap = sat23(st_r.gap);
                st_nxt.hold = '0;
                if (!dev_normal)
                begin
                    st_nxt.cs = C_IDLE;
                end
                else if (st_r.tmr >= 23'(RT_LIMIT_CYC - 1))
                begin
                    st_nxt.cs = C_IDLE; // R22 R11
                    st_nxt.cal_fault = 1'b1;
                    st_nxt.per = '0;
                end
                else if (st_r.gap >= 23'(RT_GAP_CYC - 1) && rise[I_REF])
                begin
                    st_nxt.cs = C_RT_STEP; // R7 R10
                end
            end
            C_RT_STEP:
            begin
                st_nxt.tmr = sat23(st_r.tmr);
                st_nxt.hold = st_r.hold + 10'h1;
                if (st_r.hold >= 10'(RSC_HOLD_CYC - 1))
                begin
                    st_nxt.gap = '0; // R8
                    st_nxt.cs = C_RT_WAIT;
                    if (step_ok)
                    begin
                        st_nxt.cs = C_IDLE; // R12
                        st_nxt.cal_fault = 1'b0;
                        st_nxt.per = '0;
                    end
                    else if (step_exh)
                    begin
                        st_nxt.cs = C_IDLE; // R22 R11
                        st_nxt.cal_fault = 1'b1;
                        st_nxt.per = '0;
                    end
                    else
                    begin
                        st_nxt.trim[0] = step_trim; // R3 R4
                        st_nxt.rev = step_rev;
                        st_nxt.last_cmp = cmpv;
                    end
                end
            end
        endcase
        st_nxt.short_in = (st_nxt.cs == C_INIT) || (st_nxt.cs == C_RT_STEP); // R4
        st_nxt.hold_loop = (st_nxt.cs == C_RT_STEP); // R8
        st_nxt.trim_code = st_nxt.trim[st_nxt.blk];
        st_nxt.angle_valid = st_nxt.init_done; // R9

        // Feedback DAC words
        st_nxt.sin_dac = sin10(angle); // R17
        st_nxt.cos_dac = sin10(angle + 10'h100); // R17

        // Mismatch timers in 100 ns ticks
        st_nxt.tick = (st_r.tick == 3'(RSC_TICK_CYC - 1)) ? 3'h0 : st_r.tick + 3'h1;
        if (st_r.tick == 3'h0)
        begin
            if (st_r.mt != 8'hff)
            begin
                st_nxt.mt = st_r.mt + 8'h1;
            end
            if (st_r.rper != 11'h7ff)
            begin
                st_nxt.rper = st_r.rper + 11'h1;
            end
        end
        if (rise[I_SIN])
        begin
            st_nxt.ms = st_r.mt; // R15
        end
        if (rise[I_COS])
        begin
            st_nxt.mc = st_r.mt; // R15
        end
        if (rise[I_REF])
        begin
            st_nxt.mt = '0;
            st_nxt.rper = '0;
            if (st_r.rper >= 11'(RSC_PER_MIN_TICK) && st_r.rper <= 11'(RSC_PER_MAX_TICK))
            begin
                st_nxt.auto_val = (st_r.ms > st_r.mc) ? st_r.ms : st_r.mc; // R15 R16
            end
        end
        unique case ({st_r.ph_man, st_r.ph_auto})
            2'b01: st_nxt.ref_delay = {1'b0, st_r.auto_val}; // R13 R16
            2'b10: st_nxt.ref_delay = 9'({{3{st_r.ph_val[5]}}, st_r.ph_val} * RSC_MAN_SCALE); // R14
            default: st_nxt.ref_delay = '0; // R13
        endcase

        // Diagnostics and fault pin
        st_nxt.exm = (st_r.exm != '0) ? st_r.exm - 23'h1 : '0;
        st_nxt.flags = (st_r.flags & ~w1c) | diag_set; // R19
        st_nxt.loop_flt = st_r.loop_flt | st_r.s2[I_ERR]; // R18

        // Register bus
        st_nxt.pready = setup;
        st_nxt.pslverr = 1'b0;
        if (setup)
        begin
            st_nxt.prdata = '0;
            unique case (paddr)
                RSC_CTRL_OFF: st_nxt.prdata = {18'h0, st_r.ph_val, 5'h0, st_r.ph_man,
                    st_r.ph_auto, st_r.exc_en};
                RSC_STAT_OFF:
                begin
                    st_nxt.prdata[RSC_STAT_CAL] = st_r.cal_fault;
                    st_nxt.prdata[RSC_STAT_LOOP] = st_r.loop_flt;
                    st_nxt.prdata[RSC_STAT_DIAG +: DIAG_N] = st_r.flags;
                    st_nxt.prdata[RSC_STAT_BUSY] = (st_r.cs != C_IDLE);
                    st_nxt.prdata[RSC_STAT_INIT] = st_r.init_done;
                end
                RSC_TRIM_OFF: st_nxt.prdata = {8'h0, st_r.trim};
                RSC_PHASE_OFF: st_nxt.prdata = {15'h0, st_r.auto_val, st_r.ref_delay};
                default: st_nxt.pslverr = 1'b1;
            endcase
        end
        if (wr && paddr == RSC_CTRL_OFF)
        begin
            st_nxt.exc_en = pwdata[RSC_CTRL_EXC];
            st_nxt.ph_auto = pwdata[RSC_CTRL_AUTO];
            st_nxt.ph_man = pwdata[RSC_CTRL_MAN];
            st_nxt.ph_val = pwdata[RSC_CTRL_VAL +: 6];
            if (pwdata[RSC_CTRL_EXC] && !st_r.exc_en)
            begin
                st_nxt.exm = 23'(EXC_MASK_CYC); // R21
            end
        end
        if (wr && paddr == RSC_STAT_OFF && pwdata[RSC_STAT_LOOP])
        begin
            st_nxt.loop_flt = st_r.s2[I_ERR];
        end
        st_nxt.exc_off = st_r.exc_en && (|st_r.flags[EXC_N-1:0]); // R20
        st_nxt.fault = (|st_r.flags) || st_r.loop_flt || st_r.cal_fault; // R20
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign prdata = st_r.prdata;
    assign pready = st_r.pready;
    assign pslverr = st_r.pslverr;
    assign trim_code = st_r.trim_code;
    assign trim_sel = st_r.blk;
    assign cal_short = st_r.short_in;
    assign loop_hold = st_r.hold_loop;
    assign angle_valid = st_r.angle_valid;
    assign sin_dac = st_r.sin_dac;
    assign cos_dac = st_r.cos_dac;
    assign ref_delay = st_r.ref_delay;
    assign exciter_off = st_r.exc_off;
    assign fault = st_r.fault;

    // ==========================================
    // Checks
    logic [9:0] hcnt_r;
    logic [22:0] lcnt_r;
    logic rt_on;
    assign rt_on = (st_r.cs == C_RT_WAIT) || (st_r.cs == C_RT_STEP);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            hcnt_r <= '0;
            lcnt_r <= '1;
        end
        else
        begin
            hcnt_r <= st_r.hold_loop ? hcnt_r + 10'h1 : 10'h0;
            lcnt_r <= st_r.hold_loop ? 23'h0 : sat23(lcnt_r);
        end
    end

    AST_HOLD_MAX: assert property (@(posedge pclk) disable iff (!presetn) // R8
        hcnt_r <= 10'(RSC_HOLD_CYC)) else $error("loop hold too long");
    AST_RT_FE_ONLY: assert property (@(posedge pclk) disable iff (!presetn) // R3
        rt_on |-> st_r.blk == 2'h0 && $stable(st_r.trim[3:1])) else $error("rt touched block");
    AST_RT_GAP: assert property (@(posedge pclk) disable iff (!presetn) // R7
        $rose(st_r.hold_loop) |-> lcnt_r >= 23'(RT_GAP_CYC)) else $error("trim step too soon");
    AST_ZERO_CROSS: assert property (@(posedge pclk) disable iff (!presetn) // R10
        $rose(st_r.hold_loop) |-> $past(rise[I_REF])) else $error("step off zero crossing");
    AST_MAN_DELAY: assert property (@(posedge pclk) disable iff (!presetn) // R14
        st_r.ph_man && !st_r.ph_auto |=> $signed(st_r.ref_delay)
        == 4 * $signed($past(st_r.ph_val))) else $error("manual delay wrong");
    AST_NO_DELAY: assert property (@(posedge pclk) disable iff (!presetn) // R13
        !st_r.ph_man && !st_r.ph_auto |=> st_r.ref_delay == 9'h0) else $error("delay not zero");
    AST_EXC_MASK: assert property (@(posedge pclk) disable iff (!presetn) // R21
        st_r.exm != '0 |=> (st_r.flags[EXC_N-1:0] & ~$past(st_r.flags[EXC_N-1:0])) == '0)
        else $error("masked exciter fault set");
    AST_FAIL_RETRY: assert property (@(posedge pclk) disable iff (!presetn) // R11
        $rose(st_r.cal_fault) |-> st_r.cs == C_IDLE && st_r.per == '0) else $error("no retry");
    AST_VALID: assert property (@(posedge pclk) disable iff (!presetn) // R9
        st_r.init_done ##1 rt_on |-> st_r.angle_valid) else $error("angle invalid in cal");
    AST_FAULT_PIN: assert property (@(posedge pclk) disable iff (!presetn) // R20
        st_r.cal_fault |=> st_r.fault) else $error("fault pin silent");

    COV_INIT: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(st_r.init_done) && !st_r.cal_fault);
    COV_RT_STEP: cover property (@(posedge pclk) disable iff (!presetn) $fell(st_r.hold_loop));
    COV_CAL_FAIL: cover property (@(posedge pclk) disable iff (!presetn) $rose(st_r.cal_fault));
    COV_AUTO: cover property (@(posedge pclk) disable iff (!presetn)
        st_r.ph_auto && st_r.ref_delay != '0);
endmodule

// File: verif/rsc_fe_model.sv
// Front-end model: offset comparator, exciter reference, zero crossings
`timescale 1ns/1ns
module rsc_fe_model
    import rsc_pkg::*;
#(
    parameter int TGT = 6,
    parameter int REF_HALF = 1300
)(
    input wire logic pclk,
    input wire logic [RSC_TRIM_W-1:0] trim_code,
    input wire logic cal_short,
    input wire logic stuck,
    output logic cal_cmp = 1'b0,
    output logic exciter_ref = 1'b0,
    output logic sin_zc = 1'b0,
    output logic cos_zc = 1'b0
);
    int cnt = 0;
    always @(posedge pclk)
    begin
        cnt <= (cnt == 2 * REF_HALF - 1) ? 0 : cnt + 1;
        exciter_ref <= cnt < REF_HALF;
        sin_zc <= cnt == 40;
        cos_zc <= cnt == 60;
        // Trim adds offset; unshorted output swings every cycle
        cal_cmp <= cal_short ? (!stuck && trim_code > TGT) : cnt[0];
    end
endmodule

// File: verif/tb_rsc_cal.sv
// Testbench for the resolver offset and phase calibration block
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; \
    $display("ERROR %s exp %0h got %0h", n, e, g); end end
module tb_rsc_cal
    import rsc_pkg::*;
;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [7:0] paddr = 0, diag_in = 0;
    logic [31:0] pwdata = 0, prdata, r;
    logic dev_diag = 0, dev_normal = 0, err_high = 0, stuck = 0, e;
    logic cal_cmp, exciter_ref, sin_zc, cos_zc, cal_short, loop_hold, angle_valid;
    logic exciter_off, fault;
    logic [5:0] trim_code;
    logic [1:0] trim_sel;
    logic [9:0] sin_dac, cos_dac;
    logic [8:0] ref_delay;
    logic [9:0] ang = 10'h0a5;
    int miscompares = 0, checks = 0, n, hl = 0, holds = 0, gap = 0, sr = 0, av = 0;
    logic [15:0] cw [5] = '{16'h1f05, 16'h2105, 16'h3f05, 16'h0507, 16'h0501};
    logic [8:0] ex [5] = '{9'h07c, 9'h184, 9'h1fc, 9'h000, 9'h000};
    rsc_cal #(.PERIOD_CYC(2000), .RT_GAP_CYC(600), .RT_LIMIT_CYC(20000),
        .EXC_MASK_CYC(100)) u_rsc_cal (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .dev_diag(dev_diag),
        .dev_normal(dev_normal), .angle(ang), .cal_cmp(cal_cmp), .exciter_ref(exciter_ref),
        .sin_zc(sin_zc), .cos_zc(cos_zc), .err_high(err_high), .diag_in(diag_in),
        .trim_code(trim_code), .trim_sel(trim_sel), .cal_short(cal_short),
        .loop_hold(loop_hold), .angle_valid(angle_valid), .sin_dac(sin_dac),
        .cos_dac(cos_dac), .ref_delay(ref_delay), .exciter_off(exciter_off), .fault(fault));
    rsc_fe_model u_rsc_fe_model (.pclk(pclk), .trim_code(trim_code), .cal_short(cal_short),
        .stuck(stuck), .cal_cmp(cal_cmp), .exciter_ref(exciter_ref), .sin_zc(sin_zc),
        .cos_zc(cos_zc));
    initial
    begin
        forever #10 pclk = ~pclk;
    end
    // ==========
    // APB access, held until pready is seen high
    task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task end_sim;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task poll(input logic v);
        n = 0;
        do
        begin
            repeat (500) @(posedge pclk);
            acc(0, RSC_STAT_OFF, 0);
            n++;
        end while (r[RSC_STAT_CAL] !== v && n < 200);
        `CHK("cal_fault", v, r[RSC_STAT_CAL])
    endtask
    // ==========
    // Monitors of the periodic steps
    always @(negedge pclk)
    begin
        sr = exciter_ref ? sr + 1 : 0;
        gap++;
        if (presetn && loop_hold)
        begin
            hl++;
            `CHK("trim_sel", 2'h0, trim_sel)
            `CHK("short", 1'b1, cal_short)
            if (hl == 1)
            begin
                `CHK("ref_align", 1'b1, sr >= 1 && sr <= 6)
                if (holds > 0) `CHK("gap", 1'b1, gap >= 600)
                gap = 0;
            end
        end
        else if (hl > 0)
        begin
            `CHK("hold_len", RSC_HOLD_CYC, hl)
            hl = 0;
            holds++;
        end
        if (av) `CHK("angle_valid", 1'b1, angle_valid)
        av = av | angle_valid;
    end
    initial
    begin
        repeat (110000) @(posedge pclk);
        miscompares++;
        end_sim();
    end
    // ==========
    // Test sequence
    initial
    begin
        repeat (20) @(posedge pclk);
        presetn <= 1;
        acc(0, RSC_CTRL_OFF, 0);
        `CHK("ctrl", 32'h0, r)
        acc(0, 8'h14, 0);
        `CHK("unmapped", 33'h100000000, {e, r})
        dev_diag <= 1;
        n = 0;
        while (angle_valid !== 1'b1 && n < RSC_INIT_MAX_CYC + 100)
        begin
            @(posedge pclk);
            n++;
        end
        `CHK("init_len", 1'b1, n >= RSC_INIT_MIN_CYC && n <= RSC_INIT_MAX_CYC + 4)
        acc(0, RSC_TRIM_OFF, 0);
        for (int i = 0; i < 4; i++)
            `CHK("trim", 1'b1, r[6*i+:6] >= 4 && r[6*i+:6] <= 8)
        acc(0, RSC_STAT_OFF, 0);
        `CHK("status", 2'h2, {r[RSC_STAT_INIT], r[RSC_STAT_CAL]})
        dev_diag <= 0;
        dev_normal <= 1;
        acc(1, RSC_CTRL_OFF, 1);
        diag_in <= 8'h01;
        repeat (4) @(posedge pclk);
        diag_in <= 0;
        repeat (150) @(posedge pclk);
        acc(0, RSC_STAT_OFF, 0);
        `CHK("masked", 9'h0, r[9:1])
        diag_in <= 8'h81;
        err_high <= 1;
        repeat (4) @(posedge pclk);
        diag_in <= 0;
        err_high <= 0;
        repeat (6) @(posedge pclk);
        acc(0, RSC_STAT_OFF, 0);
        `CHK("flags", 9'h103, r[9:1])
        `CHK("pins", 2'h3, {exciter_off, fault})
        acc(1, RSC_STAT_OFF, 32'h3fe);
        repeat (4) @(posedge pclk);
        acc(0, RSC_STAT_OFF, 0);
        `CHK("cleared", 11'h0, {exciter_off, fault, r[9:1]})
        for (int i = 0; i < 5; i++)
        begin
            acc(1, RSC_CTRL_OFF, {16'h0, cw[i]});
            repeat (2) @(posedge pclk);
            `CHK("ref_delay", ex[i], ref_delay)
        end
        acc(1, RSC_CTRL_OFF, 3);
        repeat (3000) @(posedge pclk);
        `CHK("auto", 1'b1, ref_delay >= 9'd11 && ref_delay <= 9'd13)
        ang <= 10'h000;
        repeat (2) @(posedge pclk);
        `CHK("dac_0", {10'h200, 10'h3fc}, {sin_dac, cos_dac})
        ang <= 10'h200;
        repeat (2) @(posedge pclk);
        `CHK("dac_180", {10'h200, 10'h004}, {sin_dac, cos_dac})
        n = 0;
        while (holds < 2 && n < 20000)
        begin
            @(posedge pclk);
            n++;
        end
        `CHK("rt_steps", 1'b1, holds >= 2)
        stuck <= 1;
        poll(1);
        `CHK("fault_pin", 1'b1, fault)
        stuck <= 0;
        poll(0);
        end_sim();
    end
endmodule
